// ---- verilog/screen_buffer_dma_emulation_decode.sv ----
/*
  Screen memory decode glue: selects screen RAM in a low window and an
  alias window, and on alias reads pushes the RAM byte into a short FIFO
  in the same bus cycle; the FIFO strobes it to the CRT row buffer at least two clocks later.
  Assumes the bus fields are synchronous to clk_sys_in and each bus cycle
  is presented as a one-cycle strobe with address and data valid.
*/
`timescale 1ns/1ps
`default_nettype none
`include "scr_decode_cfg.svh"
module screen_buffer_dma_emulation_decode (
  input  wire logic                     clk_sys_in,
  input  wire logic                     sys_rst_in,
  input  wire logic [`SCR_ADDR_W-1:0]   bus_addr_in,
  input  wire logic                     bus_mem_cycle_in,
  input  wire logic                     bus_rd_in,
  input  wire logic                     bus_wr_in,
  input  wire logic [`SCR_DATA_W-1:0]   bus_wdata_in,
  output logic                          bus_ready_out,
  output logic      [`SCR_DATA_W-1:0]   bus_rdata_out,
  output logic                          bus_rvalid_out,
  output logic                          crt_wr_out,
  output logic      [`SCR_DATA_W-1:0]   crt_data_out,
  input  wire logic                     crt_ready_in,
  output logic                          row_sel_out,
  output logic                          alias_sel_out
);
  typedef struct packed {
    logic                    rvalid;
    logic [`SCR_DATA_W-1:0]  rdata;
    logic                    crt_wr;
    logic [`SCR_DATA_W-1:0]  crt_data;
  } top_st_t;

  top_st_t                 st_ff;
  top_st_t                 nxt_st;
  logic [`SCR_DATA_W-1:0]  ram_ff [2**`SCR_RAM_AW];
  scr_decode_pkg::sel_t    sel;
  logic                    in_low;
  logic                    in_alias;
  logic                    alias_rd;
  logic                    fifo_ready;
  logic                    fifo_valid;
  logic [`SCR_DATA_W-1:0]  fifo_data;
  logic [`SCR_RAM_AW-1:0]  ram_addr;

  assign in_low   = bus_mem_cycle_in && (bus_addr_in >= `SCR_LOW_LO)
                    && (bus_addr_in <= `SCR_LOW_HI);   // R1
  assign in_alias = bus_mem_cycle_in && (bus_addr_in >= `SCR_ALIAS_LO)
                    && (bus_addr_in <= `SCR_ALIAS_HI); // R2
  // Folding drops bit 12, so both windows land on the same RAM word
  assign ram_addr = bus_addr_in[`SCR_RAM_AW-1:0];      // R2

  always_comb begin
    sel = scr_decode_pkg::SEL_NONE;
    if (in_alias) begin
      sel = scr_decode_pkg::SEL_ALIAS;
    end else if (in_low) begin
      sel = scr_decode_pkg::SEL_LOW;
    end
  end

  // Strobe only on a memory read with bit 12 high inside the screen region
  assign alias_rd = bus_rd_in && (sel == scr_decode_pkg::SEL_ALIAS)
                    && bus_addr_in[`SCR_ALIAS_BIT];     // R9 R3 R5
  // Back-pressure stalls an alias read instead of dropping a byte
  assign bus_ready_out = !alias_rd || fifo_ready;
  assign row_sel_out   = (sel != scr_decode_pkg::SEL_NONE);
  assign alias_sel_out = (sel == scr_decode_pkg::SEL_ALIAS);

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.rvalid = 1'b0;
    nxt_st.crt_wr = 1'b0;
    if (bus_rd_in && (sel != scr_decode_pkg::SEL_NONE) && bus_ready_out) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = ram_ff[ram_addr];
    end
    if (fifo_valid && crt_ready_in) begin
      nxt_st.crt_wr   = 1'b1;
      nxt_st.crt_data = fifo_data;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
    if (bus_wr_in && (sel != scr_decode_pkg::SEL_NONE)) begin
      ram_ff[ram_addr] <= bus_wdata_in;  // R5
    end
  end

  // The RAM byte is pushed in the very cycle of the read
  row_fifo #(
    .WIDTH (`SCR_DATA_W),
    .DEPTH (`SCR_FIFO_DEPTH),
    .AW    (`SCR_FIFO_AW)
  ) u_fifo (
    .clk_sys_in    (clk_sys_in),
    .sys_rst_in    (sys_rst_in),
    .in_valid_in   (alias_rd),
    .in_ready_out  (fifo_ready),
    .in_data_in    (ram_ff[ram_addr]),  // R4
    .out_valid_out (fifo_valid),
    .out_ready_in  (crt_ready_in),
    .out_data_out  (fifo_data)
  );

  assign bus_rdata_out  = st_ff.rdata;
  assign bus_rvalid_out = st_ff.rvalid;
  assign crt_wr_out     = st_ff.crt_wr;  // R3
  assign crt_data_out   = st_ff.crt_data;
endmodule
`default_nettype wire

// ---- shared/scr_decode_cfg.svh ----
/*
  Address windows, field positions and timing constants for the screen
  memory decode glue. Assumes a 20-bit processor address and an 8-bit data bus.
*/
// Functional notes
// R1: Memory accesses from 0x30 through 0x7FF select the screen RAM.
// R2: Memory accesses from 0x1030 through 0x17FF also select the screen RAM, folded onto the low window.
// R3: Every memory read in the alias window raises a row buffer write strobe together with the RAM read; here the FIFO strobes it at least 2 clocks later.
// R4: The byte read from RAM in an alias read is handed to the row buffer in that same bus cycle; the code only pushes it into the FIFO then.
// R5: Low window accesses touch the RAM only and never strobe the row buffer.
// R6: The processor must supply 80 characters to the row buffers within each 617 us row period.
// R7: On each row request the processor does a repeated_string_load of 40 words, 80 bytes, via the alias window.
// R8: After a row the processor checks for end of screen memory, wraps and stores its pointer.
// R9: The row buffer strobe is the memory read qualified by a memory cycle and address bit 12 high.
`ifndef SCR_DECODE_CFG_SVH
`define SCR_DECODE_CFG_SVH
`define SCR_ADDR_W      20
`define SCR_DATA_W      8
`define SCR_RAM_AW      11
`define SCR_LOW_LO      20'h00030
`define SCR_LOW_HI      20'h007FF
`define SCR_ALIAS_LO    20'h01030
`define SCR_ALIAS_HI    20'h017FF
`define SCR_ALIAS_BIT   12
`define SCR_ROW_CHARS   80
`define SCR_ROW_US      617
`define SCR_CLK_MHZ     125
`define SCR_ROW_CYCLES  (`SCR_ROW_US * `SCR_CLK_MHZ)
`define SCR_FIFO_DEPTH  4
`define SCR_FIFO_AW     2
`endif

// ---- shared/scr_decode_pkg.sv ----
/*
  Types for the screen memory decode glue.
  Assumes scr_decode_cfg.svh is on the include path.
*/
`include "scr_decode_cfg.svh"
package scr_decode_pkg;
  typedef logic [`SCR_ADDR_W-1:0] addr_t;
  typedef logic [`SCR_DATA_W-1:0] data_t;
  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_LOW,
    SEL_ALIAS
  } sel_t;
endpackage

// ---- verilog/row_fifo.sv ----
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module row_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4,
  parameter int AW    = 2
) (
  input  wire logic             clk_sys_in,
  input  wire logic             sys_rst_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } fifo_st_t;

  fifo_st_t         st_ff;
  fifo_st_t         nxt_st;
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready_out  = (st_ff.cnt != (AW+1)'(DEPTH));
  assign out_valid_out = (st_ff.cnt != '0);
  assign out_data_out  = mem_ff[st_ff.rp];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.wp = st_ff.wp + 1'b1;
    end
    if (pop) begin
      nxt_st.rp = st_ff.rp + 1'b1;
    end
    if (push && !pop) begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
    end else if (pop && !push) begin
      nxt_st.cnt = st_ff.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
    if (push) begin
      mem_ff[st_ff.wp] <= in_data_in;
    end
  end
endmodule
`default_nettype wire

// ---- tb/row_buf_sink.sv ----
/*
  Row buffer model on the far side of the decode glue.
  Assumes strobes from the glue are one-cycle pulses on clk_sys_in.
*/
`timescale 1ns/1ps
`default_nettype none
module row_buf_sink (
  input  wire logic       clk_sys_in,
  input  wire logic       sys_rst_in,
  input  wire logic       stall_in,
  input  wire logic       wr_in,
  input  wire logic [7:0] data_in,
  output logic            ready_out,
  output logic      [7:0] count_out,
  output logic      [7:0] last_out
);
  logic [1:0] ph_ff;
  // Refuses one cycle in four so the FIFO never drains at full rate
  assign ready_out = !stall_in && ph_ff != 2'h3;
  always_ff @(posedge clk_sys_in) begin
    ph_ff <= sys_rst_in ? 2'h0 : ph_ff + 2'h1;
    if (sys_rst_in) begin
      count_out <= 8'h00;
    end else if (wr_in) begin
      count_out <= count_out + 8'h01;
      last_out  <= data_in;
    end
  end
endmodule
`default_nettype wire

// ---- tb/scr_decode_chk_asserts.sv ----
/*
  Port checker for the screen decode glue.
  Assumes it is bound to the top module.
*/
`timescale 1ns/1ps
`default_nettype none
module scr_decode_chk (
  input wire logic        clk_sys_in,
  input wire logic        sys_rst_in,
  input wire logic [19:0] bus_addr_in,
  input wire logic        bus_mem_cycle_in,
  input wire logic        bus_rd_in,
  input wire logic        bus_ready_out,
  input wire logic        bus_rvalid_out,
  input wire logic        crt_wr_out,
  input wire logic        crt_ready_in,
  input wire logic        row_sel_out,
  input wire logic        alias_sel_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  logic [2:0] pend_ff;
  wire logic take = bus_rd_in && alias_sel_out && bus_ready_out;
  // Bytes pushed by alias reads and not yet strobed out
  always_ff @(posedge clk_sys_in)
    pend_ff <= sys_rst_in ? 3'h0 : pend_ff + {2'h0, take} - {2'h0, crt_wr_out};
  chk_low_sel: assert property (bus_mem_cycle_in && bus_addr_in inside {[20'h00030:20'h007FF]}
    |-> row_sel_out && !alias_sel_out) else $error("low window select wrong");
  chk_alias_sel: assert property (bus_mem_cycle_in && bus_addr_in inside {[20'h01030:20'h017FF]}
    |-> row_sel_out && alias_sel_out) else $error("alias window select wrong");
  chk_outside_sel: assert property (!(bus_mem_cycle_in && bus_addr_in inside
    {[20'h00030:20'h007FF], [20'h01030:20'h017FF]}) |-> !row_sel_out)
    else $error("select outside windows");
  chk_alias_bit: assert property (alias_sel_out |-> bus_mem_cycle_in && bus_addr_in[12])
    else $error("alias select without bit 12");
  chk_rd_answer: assert property (take |=> bus_rvalid_out) else $error("alias read unanswered");
  chk_strobe_cause: assert property (crt_wr_out |-> pend_ff != 3'h0)
    else $error("strobe without alias read");
  chk_strobe_soon: assert property (take && crt_ready_in |-> ##[1:8] crt_wr_out)
    else $error("alias read not strobed");
  chk_refuse_full: assert property (!bus_ready_out |-> take == 1'b0 && bus_rd_in && pend_ff == 3'h4)
    else $error("refusal without full buffer");
  cover property (take);
  cover property (!bus_ready_out);
  cover property (crt_wr_out ##1 crt_wr_out);
endmodule
bind screen_buffer_dma_emulation_decode scr_decode_chk scr_decode_chk_i (.clk_sys_in, .sys_rst_in,
  .bus_addr_in, .bus_mem_cycle_in, .bus_rd_in, .bus_ready_out, .bus_rvalid_out, .crt_wr_out,
  .crt_ready_in, .row_sel_out, .alias_sel_out);
`default_nettype wire

// ---- tb/test_screen_buffer_dma_emulation_decode.sv ----
/*
  Self-checking bench: the bench plays the processor, row_buf_sink the row buffer.
  Assumes the shared package and header are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module test_screen_buffer_dma_emulation_decode;
  logic                  clk_sys_in = 1'b0;
  logic                  sys_rst_in = 1'b1;
  scr_decode_pkg::addr_t bus_addr_in = 20'h00000;
  scr_decode_pkg::data_t bus_wdata_in = 8'h00, bus_rdata_out, crt_data_out, cnt, last;
  logic bus_mem_cycle_in = 1'b1, bus_rd_in = 1'b0, bus_wr_in = 1'b0, stall = 1'b0;
  logic bus_ready_out, bus_rvalid_out, crt_wr_out, crt_ready_in, row_sel_out, alias_sel_out;
  int n_mismatch = 0, checks_done = 0;
  always #4 clk_sys_in = ~clk_sys_in;
  screen_buffer_dma_emulation_decode screen_buffer_dma_emulation_decode_i (.clk_sys_in,
    .sys_rst_in, .bus_addr_in, .bus_mem_cycle_in, .bus_rd_in, .bus_wr_in, .bus_wdata_in,
    .bus_ready_out, .bus_rdata_out, .bus_rvalid_out, .crt_wr_out, .crt_data_out,
    .crt_ready_in, .row_sel_out, .alias_sel_out);
  row_buf_sink row_buf_sink_i (.clk_sys_in, .sys_rst_in, .stall_in(stall), .wr_in(crt_wr_out),
    .data_in(crt_data_out), .ready_out(crt_ready_in), .count_out(cnt), .last_out(last));
  task automatic chk(input bit ok, input string m);
    checks_done++;
    if (!ok) begin
      n_mismatch++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  // Called at a falling edge; returns at one with the strobe still up
  task automatic op(input logic w, m, input scr_decode_pkg::addr_t a,
                    input scr_decode_pkg::data_t d, input bit v);
    bus_wr_in = w;
    bus_rd_in = !w;
    bus_mem_cycle_in = m;
    bus_addr_in = a;
    bus_wdata_in = d;
    #1;
    while (bus_ready_out !== 1'b1) @(negedge clk_sys_in);
    @(negedge clk_sys_in);
    if (!w) chk(bus_rvalid_out === v && (!v || bus_rdata_out === d), "read answer");
  endtask
  task automatic settle;
    bus_rd_in = 1'b0;
    bus_wr_in = 1'b0;
    repeat (10) @(negedge clk_sys_in);
  endtask
  task automatic t_low;
    for (int i = 0; i < 80; i++) op(1'b1, 1'b1, 20'h00030 + 20'(i), 8'(i) ^ 8'hA5, 1'b0);
    op(1'b1, 1'b1, 20'h007FF, 8'h3C, 1'b0);
    op(1'b0, 1'b1, 20'h00030, 8'hA5, 1'b1);
    op(1'b0, 1'b1, 20'h007FF, 8'h3C, 1'b1);
    op(1'b0, 1'b1, 20'h0002F, 8'h00, 1'b0);
    op(1'b0, 1'b1, 20'h01800, 8'h00, 1'b0);
    op(1'b0, 1'b0, 20'h01030, 8'h00, 1'b0);
    settle;
    chk(cnt === 8'h00, "low window strobed");
  endtask
  task automatic t_load;
    time t0;
    t0 = $time;
    for (int i = 0; i < 80; i++) op(1'b0, 1'b1, 20'h01030 + 20'(i), 8'(i) ^ 8'hA5, 1'b1);
    chk(($time - t0) < 617000, "row period exceeded");
    settle;
    chk(cnt === 8'h50 && last === 8'hEA, "row bytes lost");
  endtask
  task automatic t_fill;
    stall = 1'b1;
    for (int i = 0; i < 4; i++) op(1'b0, 1'b1, 20'h01030 + 20'(i), 8'(i) ^ 8'hA5, 1'b1);
    #1 chk(bus_ready_out === 1'b0, "full buffer not refused");
    stall = 1'b0;
    op(1'b0, 1'b1, 20'h01034, 8'hA1, 1'b1);
    settle;
    chk(cnt === 8'h55 && last === 8'hA1, "buffer drain wrong");
  endtask
  // Alias write folds onto the RAM without a strobe; the row pointer wraps at the top
  task automatic t_wrap;
    scr_decode_pkg::addr_t ptr;
    ptr = 20'h017FF;
    op(1'b1, 1'b1, ptr, 8'h5A, 1'b0);
    op(1'b0, 1'b1, 20'h007FF, 8'h5A, 1'b1);
    for (int i = 0; i < 2; i++) begin
      op(1'b0, 1'b1, ptr, (i == 0) ? 8'h5A : 8'hA5, 1'b1);
      ptr = (ptr == 20'h017FF) ? 20'h01030 : ptr + 20'h00001;
    end
    settle;
    chk(cnt === 8'h57 && last === 8'hA5 && ptr === 20'h01031, "pointer wrap row wrong");
  endtask
  task automatic report_and_stop;
    $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    report_and_stop;
  end
  initial begin
    repeat (10) @(negedge clk_sys_in);
    sys_rst_in = 1'b0;
    chk(bus_rvalid_out === 1'b0 && crt_wr_out === 1'b0, "reset outputs");
    t_low;
    t_load;
    t_fill;
    t_wrap;
    report_and_stop;
  end
endmodule
`default_nettype wire
